//--- hdl/mrod_top.sv
// Executes literal load, accumulator store, no-op, interrupt return and option load.
`include "mrod_defs.svh"
`default_nettype none
module mrod_top
	import mrod_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic        instr_valid,
	input  wire logic [13:0] instr_word,
	input  wire logic [12:0] stack_top_entry,
	output logic             instr_ready,
	output logic             stack_pop,
	output logic             pc_load,
	output logic [12:0]      pc_value,
	output mrod_file_wr_s    file_wr,
	output logic [7:0]       accumulator,
	output logic [7:0]       irq_control_reg,
	output logic [7:0]       option_reg,
	output logic             unknown_op
);
	////////////////////////////////////////////////////////////////////////
	// Decoded word and the accept handshake.
	mrod_dec_s     dec;
	logic          take;
	logic          lit_go;
	logic          store_go;
	logic          iret_go;
	logic          optld_go;
	logic          nop_go;
	logic          unk_go;
	mrod_state_e   state_r;
	mrod_state_e   state_nxt;
	logic          ready_r;
	logic          ready_nxt;
	logic          pop_r;
	logic          pop_nxt;
	logic          pcl_r;
	logic          pcl_nxt;
	logic [12:0]   pc_r;
	logic [12:0]   pc_nxt;
	mrod_file_wr_s wr_r;
	mrod_file_wr_s wr_nxt;
	logic [7:0]    acc_r;
	logic [7:0]    acc_nxt;
	logic [7:0]    irq_r;
	logic [7:0]    irq_nxt;
	logic [7:0]    opt_r;
	logic [7:0]    opt_nxt;
	logic          unk_r;
	logic          unk_nxt;

	// Every state group asks the same question of the decoded word.
	function automatic logic op_taken(input logic tk, input mrod_op_e have,
		input mrod_op_e want);
		op_taken = tk && (have == want);
	endfunction : op_taken

	mrod_classify u_classify (
		.word (instr_word),
		.dec  (dec)
	);

	// Nothing is taken in the flush cycle, so a word offered there is refused.
	assign take     = instr_valid && (state_r == MROD_ST_EXEC);
	assign lit_go   = op_taken(take, dec.op, MROD_OP_LIT);
	assign store_go = op_taken(take, dec.op, MROD_OP_STORE);
	assign iret_go  = op_taken(take, dec.op, MROD_OP_IRET);
	assign optld_go = op_taken(take, dec.op, MROD_OP_OPTLD);
	assign nop_go   = op_taken(take, dec.op, MROD_OP_NOP);
	assign unk_go   = op_taken(take, dec.op, MROD_OP_NONE);

	////////////////////////////////////////////////////////////////////////
	// Redirect control.
	always_comb begin
		state_nxt = state_r;
		ready_nxt = ready_r;
		case (state_r)
			MROD_ST_EXEC: begin
				if (iret_go) begin
					// The refetch after a redirect costs one dead cycle.
					state_nxt = MROD_ST_FLUSH;
					ready_nxt = 1'b0;
				end else begin
					state_nxt = MROD_ST_EXEC;
					ready_nxt = 1'b1;
				end
			end
			MROD_ST_FLUSH: begin
				state_nxt = MROD_ST_EXEC;
				ready_nxt = 1'b1;
			end
			default: begin
				state_nxt = MROD_ST_EXEC;
				ready_nxt = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= MROD_ST_EXEC;
			ready_r <= 1'b1;
		end else begin
			state_r <= state_nxt;
			ready_r <= ready_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Stack pop and program counter redirect.
	always_comb begin
		pop_nxt = 1'b0;
		pcl_nxt = 1'b0;
		pc_nxt  = pc_r;
		if (iret_go) begin
			pop_nxt = 1'b1;
			pcl_nxt = 1'b1;
			pc_nxt  = stack_top_entry;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pop_r <= 1'b0;
			pcl_r <= 1'b0;
			pc_r  <= `MROD_PC_RST;
		end else begin
			pop_r <= pop_nxt;
			pcl_r <= pcl_nxt;
			pc_r  <= pc_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// File register write strobe; address and data hold after the pulse.
	always_comb begin
		wr_nxt       = wr_r;
		wr_nxt.valid = 1'b0;
		if (store_go) begin
			wr_nxt.valid = 1'b1;
			wr_nxt.addr  = dec.addr;
			wr_nxt.data  = acc_r;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wr_r <= `MROD_WR_RST;
		end else begin
			wr_r <= wr_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Store and option load read the accumulator before this edge updates it,
	// which keeps program order for back-to-back words.
	always_comb begin
		acc_nxt = acc_r;
		if (lit_go) begin
			acc_nxt = dec.literal;
		end else if (nop_go) begin
			acc_nxt = acc_r;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			acc_r <= `MROD_ACC_RST;
		end else begin
			acc_r <= acc_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Interrupt control; no clear path exists here, so the set never competes.
	always_comb begin
		irq_nxt = irq_r;
		if (iret_go) begin
			irq_nxt[`MROD_GIE_BIT] = 1'b1;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			irq_r <= `MROD_IRQCTL_RST;
		end else begin
			irq_r <= irq_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Option register load.
	always_comb begin
		opt_nxt = opt_r;
		if (optld_go) begin
			opt_nxt = acc_r;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			opt_r <= `MROD_OPTION_RST;
		end else begin
			opt_r <= opt_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Words outside this subset raise a pulse and change nothing else.
	always_comb begin
		unk_nxt = unk_go;
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			unk_r <= 1'b0;
		end else begin
			unk_r <= unk_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	assign instr_ready     = ready_r;
	assign stack_pop       = pop_r;
	assign pc_load         = pcl_r;
	assign pc_value        = pc_r;
	assign file_wr         = wr_r;
	assign accumulator     = acc_r;
	assign irq_control_reg = irq_r;
	assign option_reg      = opt_r;
	assign unknown_op      = unk_r;
endmodule : mrod_top
`default_nettype wire

//--- hdl/mrod_defs.svh
// Constants for the move and return opcode decoder.
`ifndef MROD_DEFS_SVH
`define MROD_DEFS_SVH
`define MROD_LIT_MASK    14'h3c00
`define MROD_LIT_VAL     14'h3000
`define MROD_STORE_MASK  14'h3f80
`define MROD_STORE_VAL   14'h0080
`define MROD_NOP_MASK    14'h3f9f
`define MROD_NOP_VAL     14'h0000
`define MROD_IRET_CODE   14'h0009
`define MROD_OPTLD_CODE  14'h0062
`define MROD_GIE_BIT     7
`define MROD_IRQCTL_RST  8'h00
`define MROD_OPTION_RST  8'hff
`define MROD_ACC_RST     8'h00
`define MROD_PC_RST      13'h0000
`define MROD_WR_RST      16'h0000
`endif

//--- hdl/mrod_pkg.sv
// Types for the move and return opcode decoder.
`default_nettype none
package mrod_pkg;
	typedef enum logic [2:0] {
		MROD_OP_NONE  = 3'h0,
		MROD_OP_LIT   = 3'h1,
		MROD_OP_STORE = 3'h2,
		MROD_OP_NOP   = 3'h3,
		MROD_OP_IRET  = 3'h4,
		MROD_OP_OPTLD = 3'h5
	} mrod_op_e;
	typedef enum logic [1:0] {
		MROD_ST_EXEC  = 2'b00,
		MROD_ST_FLUSH = 2'b01
	} mrod_state_e;
	typedef struct packed {
		logic       valid;
		logic [6:0] addr;
		logic [7:0] data;
	} mrod_file_wr_s;
	typedef struct packed {
		mrod_op_e   op;
		logic [7:0] literal;
		logic [6:0] addr;
	} mrod_dec_s;
endpackage : mrod_pkg
`default_nettype wire

//--- hdl/mrod_classify.sv
// Combinational classifier of one instruction word.
`include "mrod_defs.svh"
`default_nettype none
module mrod_classify
	import mrod_pkg::*;
(
	input  wire logic [13:0] word,
	output mrod_dec_s        dec
);
	function automatic logic match(input logic [13:0] w, input logic [13:0] m,
		input logic [13:0] v);
		match = (w & m) == v;
	endfunction : match

	always_comb begin
		dec.literal = word[7:0];
		dec.addr    = word[6:0];
		if (match(word, `MROD_LIT_MASK, `MROD_LIT_VAL)) begin
			dec.op = MROD_OP_LIT;
		end else if (match(word, `MROD_STORE_MASK, `MROD_STORE_VAL)) begin
			dec.op = MROD_OP_STORE;
		end else if (word == `MROD_IRET_CODE) begin
			dec.op = MROD_OP_IRET;
		end else if (word == `MROD_OPTLD_CODE) begin
			dec.op = MROD_OP_OPTLD;
		end else if (match(word, `MROD_NOP_MASK, `MROD_NOP_VAL)) begin
			dec.op = MROD_OP_NOP;
		end else begin
			dec.op = MROD_OP_NONE;
		end
	end
endmodule : mrod_classify
`default_nettype wire

//--- dv/mrod_chk.sv
// Port checker for the opcode decoder.
`default_nettype none
module mrod_chk
	import mrod_pkg::*;
(
	input wire logic          clock,
	input wire logic          rst_n,
	input wire logic          instr_valid,
	input wire logic          instr_ready,
	input wire logic          stack_pop,
	input wire logic          pc_load,
	input wire logic [13:0]   instr_word,
	input wire logic [12:0]   stack_top_entry,
	input wire logic [12:0]   pc_value,
	input wire logic [7:0]    accumulator,
	input wire logic [7:0]    irq_control_reg,
	input wire logic [7:0]    option_reg,
	input wire mrod_file_wr_s file_wr
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	wire logic t = instr_valid && instr_ready;
	wire logic [13:0] w = instr_word;
	sequence s_ir; t && w == 14'h0009; endsequence
	property p_l; t && w[13:10] == 4'hc |=> accumulator == $past(w[7:0]) && instr_ready; endproperty
	a_l: assert property (p_l) else $error("lit");
	property p_s; t && w[13:7] == 7'h01 |=> file_wr == {1'b1, $past(w[6:0]), $past(accumulator)};
	endproperty
	a_s: assert property (p_s) else $error("store");
	property p_p; s_ir |=> stack_pop && pc_load && pc_value == $past(stack_top_entry); endproperty
	a_p: assert property (p_p) else $error("pop");
	property p_g; s_ir |=> irq_control_reg[7]; endproperty
	a_g: assert property (p_g) else $error("gie");
	property p_t; s_ir |=> !instr_ready ##1 instr_ready && !pc_load; endproperty
	a_t: assert property (p_t) else $error("two");
	property p_q; pc_load |=> !pc_load && !stack_pop; endproperty
	a_q: assert property (p_q) else $error("pulse");
	property p_o; t && w == 14'h0062 |=> option_reg == $past(accumulator); endproperty
	a_o: assert property (p_o) else $error("opt");
	property p_n; t && (w & 14'h3f9f) == 0 |=> $stable(accumulator) && !file_wr.valid; endproperty
	a_n: assert property (p_n) else $error("nop");
endmodule : mrod_chk
`default_nettype wire

//--- dv/mrod_mem.sv
// Program memory model handing out queued words in order.
`default_nettype none
module mrod_mem (
	input wire logic clock,
	input wire logic instr_ready,
	output logic instr_valid,
	output logic [13:0] instr_word
);
	timeunit 1ns; timeprecision 100ps;
	logic [13:0] mem[$];
	logic tk;
	int p = 0, c = 0;
	initial begin
		instr_valid = 0;
		instr_word  = 14'h0000;
	end
	// Idles every seventh cycle unless holding a refused word, which stays on offer until taken.
	always @(posedge clock) begin
		tk = instr_valid && instr_ready;
		#1 p += tk;
		c++;
		if (!instr_valid || tk) begin
			instr_valid = p < mem.size() && c % 7 != 0;
			instr_word  = instr_valid ? mem[p] : 14'h2aaa ^ instr_word;
		end
	end
endmodule : mrod_mem
`default_nettype wire

//--- dv/move_return_opcode_decode_bench.sv
// Self-checking bench for the opcode decoder.
`default_nettype none
module move_return_opcode_decode_bench import mrod_pkg::*;;
	timeunit 1ns; timeprecision 100ps;
	logic clock = 0, rst_n = 0, instr_valid, instr_ready, stack_pop, pc_load, unknown_op, tk;
	logic [13:0] instr_word, dv[12] = '{14'h305a, 14'h00a1, 14'h0009, 14'h0062, 14'h33ff,
		14'h00ff, 14'h0000, 14'h0020, 14'h0040, 14'h0060, 14'h3fff, 14'h0009};
	logic [12:0] pc_value, stack_top_entry = 0, pcv = 0;
	logic [7:0] accumulator, irq_control_reg, option_reg, acc = 0, opt = 8'hff, irq = 0;
	mrod_file_wr_s file_wr;
	logic [55:0] q[$], e, a;
	logic [31:0] r = 32'had86;
	int n_mismatch = 0, tests_run = 0, i;
	always #20 clock = ~clock;
	mrod_mem m (
		.clock       (clock),
		.instr_ready (instr_ready),
		.instr_valid (instr_valid),
		.instr_word  (instr_word)
	);
	mrod_top dut (
		.clock           (clock),
		.rst_n           (rst_n),
		.instr_valid     (instr_valid),
		.instr_word      (instr_word),
		.stack_top_entry (stack_top_entry),
		.instr_ready     (instr_ready),
		.stack_pop       (stack_pop),
		.pc_load         (pc_load),
		.pc_value        (pc_value),
		.file_wr         (file_wr),
		.accumulator     (accumulator),
		.irq_control_reg (irq_control_reg),
		.option_reg      (option_reg),
		.unknown_op      (unknown_op)
	);
	function automatic logic [31:0] nx(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : nx
	task automatic put(input logic [13:0] x);
		logic [15:0] f = 0;
		logic pl = 0, uk = 0;
		casez (x)
		14'b1100??????????: acc = x[7:0];
		14'b0000001???????: f = {1'b1, x[6:0], acc};
		14'h0009: begin pl = 1; pcv = stack_top_entry; irq[7] = 1; end
		14'h0062: opt = acc;
		14'b0000000??00000: ;
		default: uk = 1;
		endcase
		q.push_back({acc, opt, irq, f, pl, pl, pcv, uk});
		m.mem.push_back(x);
	endtask : put
	task finish_test;
		$display("tests %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : finish_test
	// Bounded wait: a word that never completes counts as a mismatch.
	task drain(input string s);
		for (i = 0; i < 900 && q.size() > 0; i++) @(posedge clock);
		if (q.size() > 0) begin n_mismatch++; finish_test; end
		else $display("%s test done", s);
	endtask : drain
	initial forever begin
		@(posedge clock);
		tk = instr_valid && instr_ready;
		#2 if (tk) begin
			e = q.pop_front();
			a = {accumulator, option_reg, irq_control_reg, file_wr & {16{file_wr.valid}},
				pc_load, stack_pop, pc_value, unknown_op};
			tests_run++;
			if (a !== e) begin
				n_mismatch++;
				$display("[ERR] %0t %h %h", $time, e, a);
			end
		end
	end
	initial begin
		repeat (20) @(posedge clock);
		#1 rst_n = 1;
		stack_top_entry = r[12:0];
		foreach (dv[k]) put(dv[k]);
		drain("directed");
		#1 stack_top_entry = r[25:13];
		repeat (90) begin
			r = nx(r);
			case (r[12:10] % 5)
			0: put({4'hc, r[9:0]});
			1: put({7'h01, r[6:0]});
			2: put(14'h0009);
			3: put(14'h0062);
			default: put({7'h00, r[6:5], 5'h00});
			endcase
		end
		drain("random");
		finish_test;
	end
endmodule : move_return_opcode_decode_bench
bind mrod_top mrod_chk chk (
	.clock           (clock),
	.rst_n           (rst_n),
	.instr_valid     (instr_valid),
	.instr_ready     (instr_ready),
	.stack_pop       (stack_pop),
	.pc_load         (pc_load),
	.instr_word      (instr_word),
	.stack_top_entry (stack_top_entry),
	.pc_value        (pc_value),
	.accumulator     (accumulator),
	.irq_control_reg (irq_control_reg),
	.option_reg      (option_reg),
	.file_wr         (file_wr)
);
`default_nettype wire
